//--- rtl/fpwm_cfg.svh
// Purpose: named offsets, field positions, reset values and timing figures of the fan block
// Assumes: 8-bit register port, 125 MHz clock
// Notes:   definitions only
`ifndef FPWM_CFG_SVH
`define FPWM_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define FPWM_OFS_CTRL_FIRST    8'h62
`define FPWM_OFS_CTRL_SECOND   8'h63
`define FPWM_OFS_FLOOR_1       8'h64
`define FPWM_OFS_FLOOR_2       8'h65
`define FPWM_OFS_FLOOR_3       8'h66
`define FPWM_OFS_DUTY_RB_1     8'he0
`define FPWM_OFS_DUTY_RB_2     8'he1
`define FPWM_OFS_DUTY_RB_3     8'he2

// ****************************************
// field positions
// ****************************************
`define FPWM_F1_RATE_LSB       0
`define FPWM_F1_SLEW_BIT       3
`define FPWM_F1_SYNC_BIT       4
`define FPWM_F1_KEEP1_BIT      5
`define FPWM_F1_KEEP2_BIT      6
`define FPWM_F1_KEEP3_BIT      7
`define FPWM_F2_RATE3_LSB      0
`define FPWM_F2_SLEW3_BIT      3
`define FPWM_F2_RATE2_LSB      4
`define FPWM_F2_SLEW2_BIT      7

// ****************************************
// reset values and duty figures
// ****************************************
`define FPWM_CTRL_RST          8'h00
`define FPWM_FLOOR_RST         8'h80
`define FPWM_DUTY_OFF          8'h00
`define FPWM_PWM_TOP           8'hfe

// ****************************************
// ramp increments per time slot, codes 0 to 7
// ****************************************
`define FPWM_INC_0             8'h01
`define FPWM_INC_1             8'h02
`define FPWM_INC_2             8'h03
`define FPWM_INC_3             8'h05
`define FPWM_INC_4             8'h08
`define FPWM_INC_5             8'h0c
`define FPWM_INC_6             8'h18
`define FPWM_INC_7             8'h30

// ****************************************
// timing
// ****************************************
`define FPWM_CLK_MHZ           125
`define FPWM_SLOT_US           205000
`define FPWM_PWM_PRESCALE      17

`endif

//--- rtl/fpwm_pkg.sv
// Purpose: shared types of the fan block
// Assumes: nothing
// Notes:   numbers live in fpwm_cfg.svh
package fpwm_pkg;
   typedef logic [7:0] fpwm_duty_t;
   typedef logic [2:0] fpwm_rate_t;
   typedef enum logic [1:0] {FPWM_HOLD, FPWM_UP, FPWM_DOWN} fpwm_dir_t;
endpackage

//--- rtl/fpwm_chan.sv
// Purpose: one fan channel: duty slewing toward a target and the pwm comparator
// Assumes: period_start and slot_tick are one-cycle enables from the top
// Notes:   duty 0xff is full on because the counter never reaches 0xff
`timescale 1ns/1ns
`include "fpwm_cfg.svh"
module fpwm_chan
   import fpwm_pkg::*;
(
   input  wire  logic       clock,
   input  wire  logic       rst,
   input  wire  logic       slot_tick,
   input  wire  logic       period_start,
   input  wire  logic       slew_on,
   input  wire  fpwm_rate_t rate_sel,
   input  wire  fpwm_duty_t target,
   input  wire  fpwm_duty_t pwm_cnt,
   output       fpwm_duty_t duty,
   output       logic       drive
);

   fpwm_duty_t duty_reg;
   fpwm_duty_t duty_next;
   logic       drive_reg;
   logic       drive_next;
   fpwm_duty_t inc;
   fpwm_dir_t  dir;

   function automatic fpwm_duty_t rate_inc(input fpwm_rate_t code);
      unique case (code)
         3'h0: rate_inc = `FPWM_INC_0;
         3'h1: rate_inc = `FPWM_INC_1;
         3'h2: rate_inc = `FPWM_INC_2;
         3'h3: rate_inc = `FPWM_INC_3;
         3'h4: rate_inc = `FPWM_INC_4;
         3'h5: rate_inc = `FPWM_INC_5;
         3'h6: rate_inc = `FPWM_INC_6;
         3'h7: rate_inc = `FPWM_INC_7;
      endcase
   endfunction

   always_comb begin
      inc       = rate_inc(rate_sel);
      dir       = (target > duty_reg) ? FPWM_UP : (target < duty_reg) ? FPWM_DOWN : FPWM_HOLD;
      duty_next = duty_reg;
      if (slew_on) begin
         if (slot_tick) begin
            // one step per slot, clamped so the target is met exactly
            unique case (dir)
               FPWM_UP:   duty_next = (8'(target - duty_reg) <= inc) ? target
                                      : 8'(duty_reg + inc);
               FPWM_DOWN: duty_next = (8'(duty_reg - target) <= inc) ? target
                                      : 8'(duty_reg - inc);
               FPWM_HOLD: duty_next = duty_reg;
            endcase
         end
      end else if (period_start) begin
         duty_next = target;
      end
      drive_next = (pwm_cnt < duty_reg);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         duty_reg  <= `FPWM_DUTY_OFF;
         drive_reg <= 1'b0;
      end else begin
         duty_reg  <= duty_next;
         drive_reg <= drive_next;
      end
   end

   assign duty  = duty_reg;
   assign drive = drive_reg;

endmodule

//--- rtl/fpwm_top.sv
// Purpose: acoustic stage of a three-output fan pwm controller: slewing, floors, tach sync
// Assumes: target duties and below-threshold flags come from the temperature loop outside
// Notes:   register port with read data one cycle after the read strobe
//
// Operation
// - channel 2 slews toward each new target at rate from second control bits 6:4.
// - rate codes 0..7 give slot increments 1,2,3,5,8,12,24,48.
// - channel 3 rate comes from second control bits 2:0, same mapping.
// - second control bit 3 enables slewing on channel 3.
// - second control bit 7 enables slewing on channel 2.
// - first control bit 3 enables slewing on channel 1.
// - channel 1 rate comes from first control bits 2:0, same mapping.
// - first control bit 4 set syncs sense inputs 2, 3 and 4 to channel 3.
// - with that bit clear only sense inputs 3 and 4 sync to channel 3.
// - auto mode below threshold: channel 1 off, or its floor if first bit 5.
// - auto mode below threshold: channel 2 off, or its floor if first bit 6.
// - auto mode below threshold: channel 3 off, or its floor if first bit 7.
// - floor value maps linearly to duty, 0x00 off through 0xff full.
// - floor registers ignore writes while auto mode is on.
// - control registers reset to 0x00, floor registers to 0x80.
// - auto mode above threshold: fan runs at floor, rising with temperature.
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
`include "fpwm_cfg.svh"
module fpwm_top
   import fpwm_pkg::*;
#(
   parameter int SLOT_CYCLES  = `FPWM_SLOT_US * `FPWM_CLK_MHZ,
   parameter int PWM_PRESCALE = `FPWM_PWM_PRESCALE
)
(
   input  wire  logic       clock,
   input  wire  logic       rst,
   input  wire  logic [7:0] reg_addr,
   input  wire  logic [7:0] reg_wdata,
   input  wire  logic       reg_wr,
   input  wire  logic       reg_rd,
   output       logic [7:0] reg_rdata,
   input  wire  logic       auto_mode,
   input  wire  fpwm_duty_t target_duty_1,
   input  wire  fpwm_duty_t target_duty_2,
   input  wire  fpwm_duty_t target_duty_3,
   input  wire  logic       below_floor_1,
   input  wire  logic       below_floor_2,
   input  wire  logic       below_floor_3,
   output       logic       fan_drive_1,
   output       logic       fan_drive_2,
   output       logic       fan_drive_3,
   output       logic       sense_gate_2,
   output       logic       sense_gate_3,
   output       logic       sense_gate_4,
   output       logic       sense_sync_2
);

   // ****************************************
   // elaboration checks
   // ****************************************
   generate
      if (SLOT_CYCLES < 1) begin : g_bad_slot
         $error("SLOT_CYCLES must be at least one");
      end
      if (PWM_PRESCALE < 1) begin : g_bad_pre
         $error("PWM_PRESCALE must be at least one");
      end
   endgenerate

   localparam int SLOT_W = $clog2(SLOT_CYCLES + 1);
   localparam int PRE_W  = $clog2(PWM_PRESCALE + 1);

   // ****************************************
   // register file
   // ****************************************
   logic [7:0]   ctrl_first_reg;
   logic [7:0]   ctrl_first_next;
   logic [7:0]   ctrl_second_reg;
   logic [7:0]   ctrl_second_next;
   fpwm_duty_t   floor_reg [3];
   fpwm_duty_t   floor_next [3];
   logic [7:0]   rdata_reg;
   logic [7:0]   rdata_next;
   fpwm_duty_t   duty_now [3];

   always_comb begin
      ctrl_first_next  = ctrl_first_reg;
      ctrl_second_next = ctrl_second_reg;
      floor_next       = floor_reg;
      if (reg_wr) begin
         unique case (reg_addr)
            `FPWM_OFS_CTRL_FIRST:  ctrl_first_next  = reg_wdata;
            `FPWM_OFS_CTRL_SECOND: ctrl_second_next = reg_wdata;
            // the loop owns the floors in auto mode, so software cannot disturb them
            `FPWM_OFS_FLOOR_1:     if (!auto_mode) floor_next[0] = reg_wdata;
            `FPWM_OFS_FLOOR_2:     if (!auto_mode) floor_next[1] = reg_wdata;
            `FPWM_OFS_FLOOR_3:     if (!auto_mode) floor_next[2] = reg_wdata;
            default:               ;
         endcase
      end
      rdata_next = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            `FPWM_OFS_CTRL_FIRST:  rdata_next = ctrl_first_reg;
            `FPWM_OFS_CTRL_SECOND: rdata_next = ctrl_second_reg;
            `FPWM_OFS_FLOOR_1:     rdata_next = floor_reg[0];
            `FPWM_OFS_FLOOR_2:     rdata_next = floor_reg[1];
            `FPWM_OFS_FLOOR_3:     rdata_next = floor_reg[2];
            `FPWM_OFS_DUTY_RB_1:   rdata_next = duty_now[0];
            `FPWM_OFS_DUTY_RB_2:   rdata_next = duty_now[1];
            `FPWM_OFS_DUTY_RB_3:   rdata_next = duty_now[2];
            default:               rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl_first_reg  <= `FPWM_CTRL_RST;
         ctrl_second_reg <= `FPWM_CTRL_RST;
         floor_reg[0]    <= `FPWM_FLOOR_RST;
         floor_reg[1]    <= `FPWM_FLOOR_RST;
         floor_reg[2]    <= `FPWM_FLOOR_RST;
         rdata_reg       <= 8'h00;
      end else begin
         ctrl_first_reg  <= ctrl_first_next;
         ctrl_second_reg <= ctrl_second_next;
         floor_reg       <= floor_next;
         rdata_reg       <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;

   // ****************************************
   // field decode
   // ****************************************
   logic       slew_on_ch1;
   logic       slew_on_ch2;
   logic       slew_on_ch3;
   fpwm_rate_t slew_rate_sel_1;
   fpwm_rate_t slew_rate_sel_2;
   fpwm_rate_t slew_rate_sel_3;
   logic       floor_keep_ch1;
   logic       floor_keep_ch2;
   logic       floor_keep_ch3;
   logic       sense_sync_all;

   assign slew_on_ch1     = ctrl_first_reg[`FPWM_F1_SLEW_BIT];
   assign slew_on_ch2     = ctrl_second_reg[`FPWM_F2_SLEW2_BIT];
   assign slew_on_ch3     = ctrl_second_reg[`FPWM_F2_SLEW3_BIT];
   assign slew_rate_sel_1 = ctrl_first_reg[`FPWM_F1_RATE_LSB +: 3];
   assign slew_rate_sel_2 = ctrl_second_reg[`FPWM_F2_RATE2_LSB +: 3];
   assign slew_rate_sel_3 = ctrl_second_reg[`FPWM_F2_RATE3_LSB +: 3];
   assign floor_keep_ch1  = ctrl_first_reg[`FPWM_F1_KEEP1_BIT];
   assign floor_keep_ch2  = ctrl_first_reg[`FPWM_F1_KEEP2_BIT];
   assign floor_keep_ch3  = ctrl_first_reg[`FPWM_F1_KEEP3_BIT];
   assign sense_sync_all  = ctrl_first_reg[`FPWM_F1_SYNC_BIT];

   // ****************************************
   // timebase: pwm counter and ramp time slot
   // ****************************************
   logic [PRE_W-1:0]  pre_reg;
   logic [PRE_W-1:0]  pre_next;
   fpwm_duty_t        cnt_reg;
   fpwm_duty_t        cnt_next;
   logic              start_reg;
   logic              start_next;
   logic [SLOT_W-1:0] slot_reg;
   logic [SLOT_W-1:0] slot_next;
   logic              slot_tick_reg;
   logic              slot_tick_next;

   always_comb begin
      pre_next   = pre_reg;
      cnt_next   = cnt_reg;
      start_next = 1'b0;
      if (pre_reg == PRE_W'(PWM_PRESCALE - 1)) begin
         pre_next = '0;
         // period is 255 counts so that duty 0xff means always on
         if (cnt_reg == `FPWM_PWM_TOP) begin
            cnt_next   = `FPWM_DUTY_OFF;
            start_next = 1'b1;
         end else begin
            cnt_next = 8'(cnt_reg + 8'h01);
         end
      end else begin
         pre_next = PRE_W'(pre_reg + 1'b1);
      end
      slot_tick_next = 1'b0;
      if (slot_reg == SLOT_W'(SLOT_CYCLES - 1)) begin
         slot_next      = '0;
         slot_tick_next = 1'b1;
      end else begin
         slot_next = SLOT_W'(slot_reg + 1'b1);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pre_reg       <= '0;
         cnt_reg       <= `FPWM_DUTY_OFF;
         start_reg     <= 1'b0;
         slot_reg      <= '0;
         slot_tick_reg <= 1'b0;
      end else begin
         pre_reg       <= pre_next;
         cnt_reg       <= cnt_next;
         start_reg     <= start_next;
         slot_reg      <= slot_next;
         slot_tick_reg <= slot_tick_next;
      end
   end

   // ****************************************
   // target selection per channel
   // ****************************************
   fpwm_duty_t target_in [3];
   logic       below_in [3];
   logic       keep_in [3];
   logic       slew_in [3];
   fpwm_rate_t rate_in [3];
   fpwm_duty_t target_eff [3];
   logic       drive_now [3];

   assign target_in = '{target_duty_1, target_duty_2, target_duty_3};
   assign below_in  = '{below_floor_1, below_floor_2, below_floor_3};
   assign keep_in   = '{floor_keep_ch1, floor_keep_ch2, floor_keep_ch3};
   assign slew_in   = '{slew_on_ch1, slew_on_ch2, slew_on_ch3};
   assign rate_in   = '{slew_rate_sel_1, slew_rate_sel_2, slew_rate_sel_3};

   generate
      for (genvar i = 0; i < 3; i++) begin : g_ch
         always_comb begin
            if (!auto_mode) begin
               target_eff[i] = target_in[i];
            end else if (below_in[i]) begin
               // off or parked at the floor under threshold minus hysteresis
               target_eff[i] = keep_in[i] ? floor_reg[i] : `FPWM_DUTY_OFF;
            end else begin
               // floor value is a linear duty code, so it compares directly
               target_eff[i] = (target_in[i] > floor_reg[i]) ? target_in[i]
                               : floor_reg[i];
            end
         end

         fpwm_chan u_chan (
            .clock        (clock),
            .rst          (rst),
            .slot_tick    (slot_tick_reg),
            .period_start (start_reg),
            .slew_on      (slew_in[i]),
            .rate_sel     (rate_in[i]),
            .target       (target_eff[i]),
            .pwm_cnt      (cnt_reg),
            .duty         (duty_now[i]),
            .drive        (drive_now[i])
         );
      end
   endgenerate

   assign fan_drive_1 = drive_now[0];
   assign fan_drive_2 = drive_now[1];
   assign fan_drive_3 = drive_now[2];

   // ****************************************
   // tach synchronisation to the third output
   // ****************************************
   // a gated sense input is measured only while the third drive is on;
   // the gate lags the drive by one clock, negligible against a tach edge
   logic gate_2_reg;
   logic gate_2_next;
   logic gate_3_reg;
   logic gate_3_next;
   logic gate_4_reg;
   logic gate_4_next;
   logic sync_2_reg;
   logic sync_2_next;

   always_comb begin
      sync_2_next = sense_sync_all;
      gate_2_next = sense_sync_all ? drive_now[2] : 1'b1;
      gate_3_next = drive_now[2];
      gate_4_next = drive_now[2];
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         gate_2_reg <= 1'b1;
         gate_3_reg <= 1'b0;
         gate_4_reg <= 1'b0;
         sync_2_reg <= 1'b0;
      end else begin
         gate_2_reg <= gate_2_next;
         gate_3_reg <= gate_3_next;
         gate_4_reg <= gate_4_next;
         sync_2_reg <= sync_2_next;
      end
   end

   assign sense_gate_2 = gate_2_reg;
   assign sense_gate_3 = gate_3_reg;
   assign sense_gate_4 = gate_4_reg;
   assign sense_sync_2 = sync_2_reg;

endmodule

//--- sim/fpwm_properties.sv
// Purpose: port-level checks of the fan block
// Assumes: one clock, rst async active high
// Notes:   shadows mirror what software wrote
`timescale 1ns/1ns
module fpwm_properties
   import fpwm_pkg::*;
(
   input wire logic       clock,
   input wire logic       rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       auto_mode,
   input wire logic       fan_drive_3,
   input wire logic       sense_gate_2,
   input wire logic       sense_gate_3,
   input wire logic       sense_gate_4,
   input wire logic       sense_sync_2
);
   logic [7:0] shd_reg [5];
   logic [7:0] shd_next [5];
   logic [7:0] idx;
   logic [7:0] shd_rd;
   always_comb begin
      idx      = reg_addr - 8'h62;
      shd_rd   = (idx < 8'd5) ? shd_reg[idx[2:0]] : 8'h00;
      shd_next = shd_reg;
      // floors freeze in auto mode, so the shadow must too
      if (reg_wr && idx < 8'd5 && (idx < 8'd2 || !auto_mode)) begin
         shd_next[idx[2:0]] = reg_wdata;
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         shd_reg <= '{8'h00, 8'h00, 8'h80, 8'h80, 8'h80};
      end else begin
         shd_reg <= shd_next;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   chk_first_read: assert property (
      reg_rd && reg_addr == 8'h62 |=> reg_rdata == $past(shd_rd))
      else $error("first control readback wrong");
   chk_second_read: assert property (
      reg_rd && reg_addr == 8'h63 |=> reg_rdata == $past(shd_rd))
      else $error("second control readback wrong");
   chk_floor_locked: assert property (
      reg_rd && idx > 8'd1 && idx < 8'd5 |=> reg_rdata == $past(shd_rd))
      else $error("floor readback wrong");
   chk_sync_copy: assert property (
      sense_sync_2 == $past(shd_reg[0][4]))
      else $error("sync flag does not follow control bit");
   chk_gate2_sync: assert property (
      sense_sync_2 |-> sense_gate_2 == $past(fan_drive_3))
      else $error("sense gate 2 not tied to drive 3");
   chk_gate2_free: assert property (
      !sense_sync_2 |-> sense_gate_2)
      else $error("sense gate 2 closed without sync");
   chk_gate3_follow: assert property (
      sense_gate_3 == $past(fan_drive_3))
      else $error("sense gate 3 not tied to drive 3");
   chk_gate4_follow: assert property (
      sense_gate_4 == $past(fan_drive_3))
      else $error("sense gate 4 not tied to drive 3");
   cov_floor_refused: cover property (reg_wr && auto_mode && reg_addr == 8'h64);
   cov_sync_on: cover property (sense_sync_2 && fan_drive_3);
   cov_duty_read: cover property (reg_rd && reg_addr == 8'he0);
endmodule

//--- sim/fpwm_fan_model.sv
// Purpose: fan drive stage that reports the duty it saw
// Assumes: window equals one pwm period in clocks
// Notes:   a changing duty blurs one window
`timescale 1ns/1ns
module fpwm_fan_model #(
   parameter int PERIOD = 255
)
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       drive,
   output      logic [7:0] seen_duty
);
   int win;
   int highs;
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         win       <= 0;
         highs     <= 0;
         seen_duty <= 8'h00;
      end else if (win == PERIOD - 1) begin
         win       <= 0;
         highs     <= 0;
         seen_duty <= 8'((highs + int'(drive)) * 255 / PERIOD);
      end else begin
         win   <= win + 1;
         highs <= highs + int'(drive);
      end
   end
endmodule

//--- sim/fan_pwm_ramp_and_floor_control_tb.sv
// Purpose: self-checking bench of the fan block
// Assumes: short slot and prescale of 1, pwm period 255 clocks
// Notes:   duties seen by fan models and by readback
`timescale 1ns/1ns
module fan_pwm_ramp_and_floor_control_tb;
   import fpwm_pkg::*;
   typedef struct packed {
      logic [7:0]  ctrl;
      logic        am;
      logic        bel;
      logic [7:0]  tgt;
      logic [23:0] exp;
   } fpwm_row_t;
   localparam fpwm_row_t ROWS [10] = '{
      '{8'h00, 1'b0, 1'b0, 8'h40, 24'h404040},
      '{8'h00, 1'b1, 1'b1, 8'h40, 24'h000000},
      '{8'he0, 1'b1, 1'b1, 8'h40, 24'h808080},
      '{8'h20, 1'b1, 1'b1, 8'h40, 24'h800000},
      '{8'h40, 1'b1, 1'b1, 8'h40, 24'h008000},
      '{8'h80, 1'b1, 1'b1, 8'h40, 24'h000080},
      '{8'h00, 1'b1, 1'b0, 8'h40, 24'h808080},
      '{8'h00, 1'b1, 1'b0, 8'hc0, 24'hc0c0c0},
      '{8'h10, 1'b0, 1'b0, 8'hff, 24'hffffff},
      '{8'h00, 1'b0, 1'b0, 8'h80, 24'h808080}};
   localparam logic [7:0] INCS [8] = '{8'h01, 8'h02, 8'h03, 8'h05,
                                       8'h08, 8'h0c, 8'h18, 8'h30};
   logic       clock = 1'b0;
   logic       rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic       auto_mode = 1'b0;
   fpwm_duty_t target_duty_1 = 8'h00;
   fpwm_duty_t target_duty_2 = 8'h00;
   fpwm_duty_t target_duty_3 = 8'h00;
   logic       below_floor_1 = 1'b0;
   logic       below_floor_2 = 1'b0;
   logic       below_floor_3 = 1'b0;
   logic       fan_drive_1;
   logic       fan_drive_2;
   logic       fan_drive_3;
   logic       sense_gate_2;
   logic       sense_gate_3;
   logic       sense_gate_4;
   logic       sense_sync_2;
   logic [7:0] seen_1;
   logic [7:0] seen_2;
   logic [7:0] seen_3;
   logic [7:0] v;
   int         errors = 0;
   int         compares = 0;
   int         cycles = 0;
   always #4 clock = ~clock;
   fpwm_top #(.SLOT_CYCLES(8), .PWM_PRESCALE(1)) i_fpwm_top (.*);
   fpwm_fan_model i_fpwm_fan_model_1 (.clock, .rst, .drive(fan_drive_1), .seen_duty(seen_1));
   fpwm_fan_model i_fpwm_fan_model_2 (.clock, .rst, .drive(fan_drive_2), .seen_duty(seen_2));
   fpwm_fan_model i_fpwm_fan_model_3 (.clock, .rst, .drive(fan_drive_3), .seen_duty(seen_3));
   // ****
   // tasks
   // ****
   task automatic give_verdict;
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic loop_in(input fpwm_duty_t t, input logic a, input logic b);
      target_duty_1 <= t;
      target_duty_2 <= t;
      target_duty_3 <= t;
      auto_mode     <= a;
      below_floor_1 <= b;
      below_floor_2 <= b;
      below_floor_3 <= b;
   endtask
   // follows readback, each new value must be one clamped step on
   task automatic walk(input logic [7:0] a, input logic [7:0] inc, input logic [7:0] tgt);
      logic [7:0] cur;
      logic [7:0] nx;
      int         n;
      loop_in(tgt, 1'b0, 1'b0);
      rd(a, cur);
      for (n = 0; n < 2000 && cur !== tgt; n++) begin
         rd(a, nx);
         if (nx !== cur) begin
            if (tgt > cur) begin
               chk({16'h0000, nx}, {16'h0000, (tgt - cur > inc) ? cur + inc : tgt});
            end else begin
               chk({16'h0000, nx}, {16'h0000, (cur - tgt > inc) ? cur - inc : tgt});
            end
            cur = nx;
         end
      end
      chk({16'h0000, cur}, {16'h0000, tgt});
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles >= 60000) begin
         errors++;
         give_verdict();
      end
   end
   // ****
   // sequence
   // ****
   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      for (int a = 8'h62; a < 8'h68; a++) begin
         rd(8'(a), v);
         chk({16'h0000, v}, (a < 8'h64) ? 24'h0 : (a < 8'h67) ? 24'h80 : 24'h0);
      end
      $display("reset values done");
      foreach (ROWS[i]) begin
         wr(8'h62, ROWS[i].ctrl);
         loop_in(ROWS[i].tgt, ROWS[i].am, ROWS[i].bel);
         // new duty lands up to one period late, then one blurred and one clean window
         repeat (1020) @(posedge clock);
         chk({seen_1, seen_2, seen_3}, ROWS[i].exp);
      end
      $display("table done");
      loop_in(8'h00, 1'b0, 1'b0);
      wr(8'h64, 8'h40);
      rd(8'h64, v);
      chk({16'h0000, v}, 24'h40);
      @(posedge clock);
      loop_in(8'h00, 1'b1, 1'b1);
      wr(8'h64, 8'hff);
      wr(8'h66, 8'h11);
      wr(8'h62, 8'h20);
      rd(8'h64, v);
      chk({16'h0000, v}, 24'h40);
      rd(8'h66, v);
      chk({16'h0000, v}, 24'h80);
      repeat (1020) @(posedge clock);
      chk({seen_1, seen_2, seen_3}, 24'h400000);
      $display("floor lock done");
      for (int c = 0; c < 3; c++) begin
         for (int k = 0; k < 8; k++) begin
            wr(8'h62, 8'h00);
            wr(8'h63, 8'h00);
            loop_in(8'h00, 1'b0, 1'b0);
            repeat (510) @(posedge clock);
            rd(8'he0 + 8'(c), v);
            chk({16'h0000, v}, 24'h0);
            if (c == 0) begin
               wr(8'h62, 8'h08 | 8'(k));
            end else if (c == 1) begin
               wr(8'h63, 8'h80 | 8'(k << 4));
            end else begin
               wr(8'h63, 8'h08 | 8'(k));
            end
            walk(8'he0 + 8'(c), INCS[k], 8'h80);
            walk(8'he0 + 8'(c), INCS[k], 8'h00);
         end
         $display("slew channel %0d done", c + 1);
      end
      give_verdict();
   end
endmodule
bind fpwm_top fpwm_properties i_fpwm_properties (
   .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .auto_mode(auto_mode),
   .fan_drive_3(fan_drive_3), .sense_gate_2(sense_gate_2), .sense_gate_3(sense_gate_3),
   .sense_gate_4(sense_gate_4), .sense_sync_2(sense_sync_2));
